// ### hdl/power_reduction_mode_control.sv
// power reduction mode controller: mode register, wake qualification, oscillator warm-up
`include "pwr_mode_map.svh"
`timescale 1ns/10ps
`default_nettype none
module power_reduction_mode_control
	import pwr_mode_pkg::*;
#(
	parameter int WARM_WIDTH = 22,
	parameter int RC_WARM = `RC_WARM_CYCLES,
	parameter int XTAL_WARM = `XTAL_WARM_CYCLES,
	parameter int EXT_WARM = `EXT_WARM_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire bus_req_t bus,
	output logic [7:0] rdata,
	input wire logic ext_interrupt_pin_a_n,
	input wire logic ext_interrupt_pin_b_n,
	input wire int_src_t int_src,
	input wire rst_src_t rst_src,
	output logic cpu_halt,
	output logic osc_run,
	output logic rc_osc_en,
	output logic bod_en,
	output logic cmp_en,
	output logic wdt_run,
	output logic rtc_run,
	output logic wake_reset
);

////////////////////////////////////////////////////////////////////////////////
	pm_state_t state;
	logic [1:0] mode;
	logic [7:0] power_control_reg;
	logic [7:0] secondary_power_control_reg;
	logic [7:0] interrupt_enable_reg0;
	logic [7:0] wake_cfg;
	logic pin_a_level, pin_b_level;
	logic [6:0] req_vec, allow_mask;
	logic [1:0] clk_sel;
	logic watchdog_clock_select, rtc_enable, cmp_on, rtc_power_down, cmp_power_down;
	logic global_interrupt_enable;
	logic low_power, deep, total_pd, keep_xtal;
	logic next_bod_en, next_cmp_en, next_wdt_run, next_rtc_run;
	logic int_hit, reset_hit, wake_any;
	logic pctrl_wr, warm_start, warm_done;
	logic [WARM_WIDTH-1:0] warm_len;

////////////////////////////////////////////////////////////////////////////////
	// pins come from outside the clock domain; active low, level sensed
	// the agreement flop costs a clock: a falling pin is seen four edges later
	pin_sync3 #(.RESET_VAL(1'b1)) sync_a (
		.clock(clock),
		.rst(rst),
		.pin(ext_interrupt_pin_a_n),
		.level(pin_a_level)
	);
	pin_sync3 #(.RESET_VAL(1'b1)) sync_b (
		.clock(clock),
		.rst(rst),
		.pin(ext_interrupt_pin_b_n),
		.level(pin_b_level)
	);

	// field views of the configuration registers
	assign clk_sel = wake_cfg[`CLKSEL_MSB:`CLKSEL_LSB];
	assign watchdog_clock_select = wake_cfg[`WATCHDOG_CLOCK_SELECT_BIT];
	assign rtc_enable = wake_cfg[`RTC_ON_BIT];
	assign cmp_on = wake_cfg[`CMP_ON_BIT];
	assign rtc_power_down = secondary_power_control_reg[`RTC_POWER_DOWN_BIT];
	assign cmp_power_down = secondary_power_control_reg[`VCPD_BIT];
	assign global_interrupt_enable = interrupt_enable_reg0[`GIE_BIT];

	// mode in force; deep covers both power-down modes
	assign low_power = (state != ST_RUN);
	assign deep = (state == ST_PD);
	assign total_pd = deep && (mode == `MODE_TPD);

////////////////////////////////////////////////////////////////////////////////
	// peripheral keep-alive decisions
	assign next_bod_en = !total_pd;
	assign next_cmp_en = !total_pd && !(cmp_power_down && !cmp_on);
	assign next_wdt_run = !deep || watchdog_clock_select;
	assign next_rtc_run = rtc_enable && !(deep && rtc_power_down);
	// crystal kept alive only for an RTC that uses it
	assign keep_xtal = next_rtc_run && (clk_sel == `CLK_XTAL);

////////////////////////////////////////////////////////////////////////////////
	// wake request vector, bit order matches the interrupt enable register
	// comparator, brownout and watchdog requests are masked by their keep-alive so those stopped blocks cannot raise a stale request; the RTC request is not
	assign req_vec = {int_src.cmp && next_cmp_en, int_src.bod && next_bod_en, int_src.wdt && next_wdt_run,
		int_src.rtc, !pin_b_level, int_src.kbd, !pin_a_level};

	// total power-down narrows the accepted sources
	assign allow_mask = total_pd ? `TPD_WAKE_MASK : 7'h7F;

	// interrupts need their own enable and the global enable
	assign int_hit = global_interrupt_enable && |(req_vec & interrupt_enable_reg0[6:0] & allow_mask);

	// resets need their enable; brownout reset absent in total power-down
	// a watchdog reset counts only while the watchdog itself is kept running
	assign reset_hit = |({rst_src.bod && next_bod_en, rst_src.wdt && next_wdt_run, rst_src.pin}
		& wake_cfg[`RSTEN_MSB:`RSTEN_LSB]);

	assign wake_any = int_hit || reset_hit;

	assign pctrl_wr = bus.wr && (bus.addr == `PCTRL_ADDR);

////////////////////////////////////////////////////////////////////////////////
	// requests in warm-up are dropped: the timer is loaded and a restart would stretch the wait
	// mode sequencer
	always_ff @(posedge clock) begin
		if (rst) begin
			state <= ST_RUN;
		end else begin
			case (state)
				ST_RUN: begin
					if (pctrl_wr) begin
						case (bus.wdata[`MODE_MSB:`MODE_LSB])
							`MODE_IDLE: state <= ST_IDLE;
							`MODE_PD: state <= ST_PD;
							`MODE_TPD: state <= ST_PD;
							default: state <= ST_RUN;
						endcase
					end
				end
				ST_IDLE: begin
					if (wake_any) begin
						state <= ST_RUN;
					end
				end
				ST_PD: begin
					if (wake_any) begin
						state <= ST_WARM;
					end
				end
				ST_WARM: begin
					if (warm_done) begin
						state <= ST_RUN;
					end
				end
				default: state <= ST_RUN;
			endcase
		end
	end

////////////////////////////////////////////////////////////////////////////////
	// warm-up length follows the selected clock source
	// a source change during warm-up would alter warm_len, not the loaded count; the core is halted, so none comes
	assign warm_start = deep && wake_any;
	always_comb begin
		case (clk_sel)
			`CLK_RC: warm_len = WARM_WIDTH'(RC_WARM);
			`CLK_EXT: warm_len = WARM_WIDTH'(EXT_WARM);
			default: warm_len = WARM_WIDTH'(XTAL_WARM);
		endcase
	end

	warm_timer #(.WIDTH(WARM_WIDTH)) warm (
		.clock(clock),
		.rst(rst),
		.start(warm_start),
		.length(warm_len),
		.done(warm_done)
	);

////////////////////////////////////////////////////////////////////////////////
	// mode field: taken on write, cleared when the core is running again
	always_ff @(posedge clock) begin
		if (rst) begin
			mode <= `MODE_NORMAL;
		end else if (state == ST_RUN && pctrl_wr) begin
			mode <= bus.wdata[`MODE_MSB:`MODE_LSB];
		end else if ((state == ST_IDLE && wake_any) || (state == ST_WARM && warm_done)) begin
			mode <= `MODE_NORMAL;
		end
	end

	// remaining control registers; the core is halted outside run so writes land only there
	always_ff @(posedge clock) begin
		if (rst) begin
			power_control_reg <= `PCTRL_RESET;
			secondary_power_control_reg <= `PCTRL2_RESET;
			interrupt_enable_reg0 <= `IRQ_EN_RESET;
			wake_cfg <= `WAKE_CFG_RESET;
		end else if (bus.wr) begin
			case (bus.addr)
				`PCTRL_ADDR: power_control_reg <= {bus.wdata[7:6], 1'b0, bus.wdata[4:2], 2'h0};
				`PCTRL2_ADDR: secondary_power_control_reg <= {bus.wdata[7], 1'b0, bus.wdata[5:1], 1'b0};
				`IRQ_EN_ADDR: interrupt_enable_reg0 <= bus.wdata;
				`WAKE_CFG_ADDR: wake_cfg <= bus.wdata;
				default: ;
			endcase
		end
	end

	// read data one cycle after the strobe, zero for unmapped offsets
	always_ff @(posedge clock) begin
		if (rst) begin
			rdata <= 8'h00;
		end else if (bus.rd) begin
			case (bus.addr)
				`PCTRL_ADDR: rdata <= {power_control_reg[7:2], mode};
				`PCTRL2_ADDR: rdata <= secondary_power_control_reg;
				`IRQ_EN_ADDR: rdata <= interrupt_enable_reg0;
				`WAKE_CFG_ADDR: rdata <= wake_cfg;
				`PSTAT_ADDR: rdata <= {1'b0, osc_run, rc_osc_en, bod_en, cmp_en, wdt_run, state};
				default: rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

////////////////////////////////////////////////////////////////////////////////
	// registered outputs; they trail the state by one clock
	// the oscillator therefore restarts one clock after the wake edge, inside the warm-up
	always_ff @(posedge clock) begin
		if (rst) begin
			cpu_halt <= 1'b0;
			osc_run <= 1'b1;
			rc_osc_en <= 1'b0;
			bod_en <= 1'b1;
			cmp_en <= 1'b1;
			wdt_run <= 1'b1;
			rtc_run <= 1'b0;
		end else begin
			cpu_halt <= low_power;
			osc_run <= !deep || keep_xtal;
			rc_osc_en <= (clk_sel == `CLK_RC) && (!deep || rtc_enable);
			bod_en <= next_bod_en;
			cmp_en <= next_cmp_en;
			wdt_run <= next_wdt_run;
			rtc_run <= next_rtc_run;
		end
	end

	// one-cycle pulse when a reset source ends a low-power mode
	always_ff @(posedge clock) begin
		if (rst) begin
			wake_reset <= 1'b0;
		end else begin
			wake_reset <= low_power && state != ST_WARM && reset_hit;
		end
	end

////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// cycles spent warming, so the exit can be held against the programmed length
	logic [WARM_WIDTH-1:0] warm_cycles;
	always_ff @(posedge clock) begin
		if (rst || state != ST_WARM) begin
			warm_cycles <= '0;
		end else begin
			warm_cycles <= warm_cycles + 1'b1;
		end
	end

	sequence run_write_s(logic [1:0] m);
		state == ST_RUN && pctrl_wr && bus.wdata[1:0] == m;
	endsequence
	sequence deep_wake_s;
		state == ST_PD && wake_any;
	endsequence
	// oscillator is back one clock after the wake edge; core stays halted
	sequence warm_s;
		state == ST_WARM && cpu_halt && osc_run;
	endsequence

	normal_after_reset_a: assert property ($fell(rst) |-> state == ST_RUN && mode == 2'h0)
		else $error("not in normal mode after reset");
	idle_entry_a: assert property (run_write_s(2'h1) |=> state == ST_IDLE && mode == 2'h1 ##1 cpu_halt)
		else $error("idle write did not halt the core");
	idle_exit_a: assert property (state == ST_IDLE && wake_any |=> state == ST_RUN ##1 !cpu_halt)
		else $error("idle not left on wake");
	pd_osc_stop_a: assert property (run_write_s(2'h2) ##1 (state == ST_PD && !keep_xtal) |=> !osc_run)
		else $error("oscillator still running in power-down");
	pd_bod_on_a: assert property (state == ST_PD && mode == 2'h2 |=> bod_en)
		else $error("brownout off in power-down");
	tpd_analog_off_a: assert property (state == ST_PD && mode == 2'h3 |=> !bod_en && !cmp_en)
		else $error("brownout or comparator on in total power-down");
	tpd_ignore_a: assert property (state == ST_PD && mode == 2'h3 && !reset_hit
		&& (req_vec & 7'h1F) == 7'h00 |=> state == ST_PD)
		else $error("comparator or brownout woke total power-down");
	warm_hold_a: assert property (deep_wake_s |=> state == ST_WARM ##1 warm_s[*8])
		else $error("execution resumed before warm-up");
	rc_off_a: assert property (state == ST_PD && !(clk_sel == 2'h1 && rtc_enable) |=> !rc_osc_en)
		else $error("rc oscillator left on in power-down");
	wdt_keep_a: assert property (state == ST_PD && watchdog_clock_select |=> wdt_run)
		else $error("watchdog stopped in power-down");
	rtc_keep_a: assert property (state == ST_PD && rtc_enable && !rtc_power_down |=> rtc_run)
		else $error("rtc stopped in power-down");
	mode_read_a: assert property (bus.rd && bus.addr == 8'h87 |=> rdata[1:0] == $past(mode))
		else $error("mode field readback wrong");

	// warm-up timing against the helper count
	warm_length_a: assert property (state == ST_WARM && warm_done |-> warm_cycles == warm_len)
		else $error("warm-up length differs from the selected source");
	warm_early_a: assert property (state == ST_WARM && warm_cycles < warm_len |=> state == ST_WARM)
		else $error("warm-up ended early");
	pd_halt_a: assert property (state == ST_PD |=> cpu_halt)
		else $error("core running in power-down");

	// keep-alive outputs in the low-power modes
	idle_periph_a: assert property (state == ST_IDLE |=> osc_run && bod_en && wdt_run)
		else $error("peripheral stopped in idle");
	tpd_rc_off_a: assert property (state == ST_PD && mode == 2'h3
		&& !(clk_sel == 2'h1 && rtc_enable) |=> !rc_osc_en)
		else $error("rc oscillator left on in total power-down");
	cmp_off_a: assert property (!total_pd && cmp_power_down && !cmp_on |=> !cmp_en)
		else $error("comparators on after their power-down");
	pd_wdt_off_a: assert property (state == ST_PD && !watchdog_clock_select |=> !wdt_run)
		else $error("watchdog running without its clock select");

	// wake qualification
	reset_wake_a: assert property ((state == ST_IDLE || state == ST_PD) && reset_hit |=> wake_reset)
		else $error("reset wake not flagged");
	run_free_a: assert property (state == ST_RUN |=> !cpu_halt)
		else $error("core halted in normal mode");
	tpd_wake_a: assert property (state == ST_PD && mode == 2'h3 && global_interrupt_enable
		&& |(req_vec[4:0] & interrupt_enable_reg0[4:0]) |=> state == ST_WARM)
		else $error("listed source did not wake total power-down");
endmodule
`default_nettype wire

// ### hdl/pwr_mode_map.svh
// register offsets, field positions, reset values and timing counts of the power mode controller
`ifndef PWR_MODE_MAP_SVH
`define PWR_MODE_MAP_SVH
`define PCTRL_ADDR 8'h87
`define PCTRL2_ADDR 8'hB5
`define IRQ_EN_ADDR 8'hA8
`define WAKE_CFG_ADDR 8'hC0
`define PSTAT_ADDR 8'hC1
`define PCTRL_RESET 8'h00
`define PCTRL2_RESET 8'h00
`define IRQ_EN_RESET 8'h00
`define WAKE_CFG_RESET 8'h00
`define MODE_LSB 0
`define MODE_MSB 1
`define GF0_BIT 2
`define GF1_BIT 3
`define BOI_BIT 4
`define VCPD_BIT 5
`define RTC_POWER_DOWN_BIT 7
`define GIE_BIT 7
`define CLKSEL_LSB 0
`define CLKSEL_MSB 1
`define WATCHDOG_CLOCK_SELECT_BIT 2
`define RTC_ON_BIT 3
`define CMP_ON_BIT 4
`define RSTEN_LSB 5
`define RSTEN_MSB 7
`define MODE_NORMAL 2'h0
`define MODE_IDLE 2'h1
`define MODE_PD 2'h2
`define MODE_TPD 2'h3
`define CLK_XTAL 2'h0
`define CLK_RC 2'h1
`define CLK_EXT 2'h2
`define TPD_WAKE_MASK 7'h1F
`define XTAL_WARM_CYCLES 1024
`define EXT_WARM_CYCLES 32
`define RC_WARM_MS 200
`define CLOCK_HZ 10000000
`define RC_WARM_CYCLES (`RC_WARM_MS * (`CLOCK_HZ / 1000))
`endif

// ### hdl/pwr_mode_pkg.sv
// types shared by the power mode controller files
package pwr_mode_pkg;
	typedef enum logic [1:0] {ST_RUN, ST_IDLE, ST_PD, ST_WARM} pm_state_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;
	typedef struct packed {
		logic cmp;
		logic bod;
		logic wdt;
		logic rtc;
		logic kbd;
	} int_src_t;
	typedef struct packed {
		logic bod;
		logic wdt;
		logic pin;
	} rst_src_t;
endpackage

// ### hdl/pin_sync3.sv
// three-stage synchroniser for an asynchronous pin with agreement filter
`timescale 1ns/10ps
`default_nettype none
module pin_sync3 #(
	parameter logic RESET_VAL = 1'b1
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic pin,
	output logic level
);
	logic s1, s2, s3;
	// first stage feeds only the second
	always_ff @(posedge clock) begin
		if (rst) begin
			s1 <= RESET_VAL;
			s2 <= RESET_VAL;
			s3 <= RESET_VAL;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
		end
	end
	// a change counts once stages two and three agree
	always_ff @(posedge clock) begin
		if (rst) begin
			level <= RESET_VAL;
		end else if (s2 == s3) begin
			level <= s3;
		end
	end
endmodule
`default_nettype wire

// ### hdl/warm_timer.sv
// oscillator warm-up down counter
`timescale 1ns/10ps
`default_nettype none
module warm_timer #(
	parameter int WIDTH = 22
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic start,
	input wire logic [WIDTH-1:0] length,
	output logic done
);
	logic [WIDTH-1:0] count;
	// load on start, then count down to zero
	always_ff @(posedge clock) begin
		if (rst) begin
			count <= '0;
		end else if (start) begin
			count <= length;
		end else if (count != '0) begin
			count <= count - 1'b1;
		end
	end
	// one-cycle pulse as the last cycle of the wait ends
	always_ff @(posedge clock) begin
		if (rst) begin
			done <= 1'b0;
		end else begin
			done <= !start && (count == {{(WIDTH-1){1'b0}}, 1'b1});
		end
	end
endmodule
`default_nettype wire

// ### bench/wake_source_model.sv
// far-side model: wake-up interrupt, reset and pin sources in front of the controller
`timescale 1ns/10ps
`default_nettype none
module wake_source_model
	import pwr_mode_pkg::*;
(
	input wire logic clock,
	input wire logic go,
	input wire logic [9:0] sel,
	input wire logic cpu_halt,
	output int_src_t int_src,
	output rst_src_t rst_src,
	output logic pin_a_n,
	output logic pin_b_n
);
	logic [9:0] active = 10'h000;
	////////////////////////////////////////////////////////////
	// a request stays up until the core runs, like a level source that waits to be serviced
	always @(posedge clock) begin
		if (go)
			active <= sel;
		else if (cpu_halt === 1'b0)
			active <= 10'h000;
	end
	// pins idle high on their pull-ups; held low as a level so a stopped clock still sees them
	assign pin_a_n = !active[8];
	assign pin_b_n = !active[9];
	assign int_src = active[4:0];
	assign rst_src = active[7:5];
endmodule
`default_nettype wire

// ### bench/power_reduction_mode_control_bench.sv
// randomised self-checking bench for the power reduction mode controller
`timescale 1ns/10ps
`default_nettype none
module power_reduction_mode_control_bench
	import pwr_mode_pkg::*;
;
	logic clock = 1'b0;
	logic rst = 1'b1;
	bus_req_t bus = '0;
	logic [7:0] rdata;
	logic pin_a_n, pin_b_n, cpu_halt, osc_run, rc_osc_en, bod_en, cmp_en, wdt_run, rtc_run, wake_reset;
	int_src_t int_src;
	rst_src_t rst_src;
	logic go = 1'b0;
	logic [9:0] sel = 10'h000;
	logic saw_reset = 1'b0;
	int miscompares = 0;
	int total_checks = 0;
	logic [31:0] seed = 32'h907E;
	logic [9:0] tpd_src [4] = '{10'h004, 10'h002, 10'h001, 10'h200};
	////////////////////////////////////////////////////////////
	// clock, design and far side
	always #50 clock = !clock;
	power_reduction_mode_control #(.RC_WARM(40)) DUT (.clock(clock), .rst(rst), .bus(bus), .rdata(rdata),
		.ext_interrupt_pin_a_n(pin_a_n), .ext_interrupt_pin_b_n(pin_b_n), .int_src(int_src),
		.rst_src(rst_src), .cpu_halt(cpu_halt), .osc_run(osc_run), .rc_osc_en(rc_osc_en), .bod_en(bod_en),
		.cmp_en(cmp_en), .wdt_run(wdt_run), .rtc_run(rtc_run), .wake_reset(wake_reset));
	wake_source_model partner (.clock(clock), .go(go), .sel(sel), .cpu_halt(cpu_halt), .int_src(int_src),
		.rst_src(rst_src), .pin_a_n(pin_a_n), .pin_b_n(pin_b_n));
	// the pulse lasts one cycle only, so it is caught here rather than polled; a new request clears it
	always @(posedge clock)
		if (go)
			saw_reset <= 1'b0;
		else if (wake_reset === 1'b1)
			saw_reset <= 1'b1;
	////////////////////////////////////////////////////////////
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	// expected {osc_run, rc_osc_en, bod_en, cmp_en, wdt_run, rtc_run}
	function automatic logic [5:0] keep_alive(input logic [1:0] m, input logic [7:0] cfg, input logic [7:0] p2);
		logic rtc;
		rtc = cfg[3] && !(m[1] && p2[7]);
		return {!m[1] || (cfg[1:0] == 2'h0 && rtc), cfg[1:0] == 2'h1 && (!m[1] || cfg[3]), m != 2'h3,
			m != 2'h3 && !(p2[5] && !cfg[4]), !m[1] || cfg[2], rtc};
	endfunction
	function automatic int warm_len(input logic [7:0] cfg);
		return cfg[1:0] == 2'h0 ? 1024 : (cfg[1:0] == 2'h1 ? 40 : 32);
	endfunction
	task automatic complete_run;
		$display("checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic check(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask
	////////////////////////////////////////////////////////////
	// register port: one-cycle strobes, read data only in the following cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge clock);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		bus.rd <= 1'b0;
		#1;
		check((rdata & m) === (e & m), "read data");
	endtask
	task automatic do_reset;
		@(posedge clock);
		rst <= 1'b1;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		#1;
		check({cpu_halt, osc_run, rc_osc_en, bod_en, cmp_en, wdt_run, rtc_run, wake_reset} === 8'h5C, "reset outputs");
	endtask
	// configure, enter a low-power mode, raise the selected sources and time the return to run
	task automatic sleep_case(input logic [1:0] m, input logic [7:0] cfg, input logic [7:0] p2,
		input logic [7:0] ien, input logic [9:0] s, input bit wakes);
		int n;
		int e;
		int lim;
		logic [5:0] msk;
		wr(8'hC0, cfg);
		wr(8'hB5, p2);
		wr(8'hA8, ien);
		wr(8'h87, {3'b000, ien[5], 2'b00, m});
		repeat (3) @(posedge clock);
		#1;
		// system oscillator on the RC source in power-down is left open, so not compared
		msk = (m[1] && cfg[1:0] == 2'h1) ? 6'h1F : 6'h3F;
		check(cpu_halt === 1'b1, "core not halted");
		check((({osc_run, rc_osc_en, bod_en, cmp_en, wdt_run, rtc_run} ^ keep_alive(m, cfg, p2)) & msk) === 6'h00,
			"keep-alive outputs");
		rd(8'h87, {6'h00, m}, 8'h03);
		e = ((m == 2'h1) ? 3 : warm_len(cfg) + 4) + ((s[9:8] != 2'b00) ? 4 : 0);
		lim = wakes ? e + 3 : 40;
		@(posedge clock);
		sel <= s;
		go <= 1'b1;
		n = 0;
		while (n < lim && (n < 2 || cpu_halt !== 1'b0)) begin
			@(posedge clock);
			if (n == 0)
				go <= 1'b0;
			#1;
			n++;
		end
		if (!wakes) begin
			check(cpu_halt === 1'b1, "woke on a refused source");
			rd(8'hC1, {6'h00, m[1] ? 2'h2 : 2'h1}, 8'h03);
			do_reset;
		end else if (n == lim) begin
			check(1'b0, "no wake");
			complete_run;
		end else begin
			check(n >= e - 1 && n <= e + 1, "wake delay");
			check(saw_reset === (s[7:5] != 3'b000), "reset wake pulse");
			rd(8'h87, 8'h00, 8'h03);
		end
	endtask
	////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		do_reset;
		rd(8'h87, 8'h00, 8'hFF);
		for (int i = 0; i < 8; i++) begin
			seed = next_rand(seed);
			wr(8'h87, seed[7:0] & 8'hFC);
			rd(8'h87, seed[7:0] & 8'hDC, 8'hFF);
			wr(8'hB5, seed[15:8]);
			rd(8'hB5, seed[15:8] & 8'hBE, 8'hFF);
			wr(8'hC0, seed[23:16] & 8'hFE);
			rd(8'hC0, seed[23:16] & 8'hFE, 8'hFF);
			rd(8'h10, 8'h00, 8'hFF);
		end
		do_reset;
		sleep_case(2'h1, 8'h00, 8'h00, 8'h82, 10'h001, 1'b1);
		sleep_case(2'h1, 8'h00, 8'h00, 8'h02, 10'h001, 1'b0);
		sleep_case(2'h1, 8'h20, 8'h00, 8'h00, 10'h020, 1'b1);
		sleep_case(2'h2, 8'h1C, 8'h00, 8'h82, 10'h001, 1'b1);
		sleep_case(2'h2, 8'h01, 8'h20, 8'hA0, 10'h008, 1'b1);
		sleep_case(2'h2, 8'h0A, 8'h80, 8'h81, 10'h100, 1'b1);
		sleep_case(2'h2, 8'h00, 8'h00, 8'h00, 10'h020, 1'b0);
		sleep_case(2'h2, 8'h02, 8'h00, 8'h90, 10'h004, 1'b0);
		sleep_case(2'h3, 8'h19, 8'h00, 8'hE0, 10'h018, 1'b0);
		sleep_case(2'h3, 8'h46, 8'h00, 8'h00, 10'h040, 1'b1);
		for (int i = 0; i < 4; i++)
			sleep_case(2'h3, 8'h0E, 8'h00, 8'h9F, tpd_src[i], 1'b1);
		complete_run;
	end
endmodule
`default_nettype wire
